// ---- src/smu_mul_core.sv ----
/*
  Combinational multiply datapath of the signed multiply unit: selects halfwords, forms
  the product of the chosen operation and splits it over the low and high result words.
  Assumes its caller registers the result and applies the condition.
*/
`timescale 1ns/1ns

module smu_mul_core (
  // Operands
  input logic [31:0] opa,
  input logic [31:0] opb,
  // Operation
  input smu_pkg::smu_ctrl_type ctrl,
  // Result
  output smu_pkg::smu_result_type res
);
  import smu_pkg::*;

  logic signed [15:0] half_a;
  logic signed [15:0] half_b;
  logic signed [31:0] half_prod;
  logic signed [63:0] long_prod;
  logic signed [47:0] word_prod;
  logic [31:0] swap_b;
  logic signed [31:0] dual_p1;
  logic signed [31:0] dual_p2;
  logic [31:0] dual_diff;

  assign half_a = ctrl.n_high ? opa[31:16] : opa[15:0]; // RULE_02
  assign half_b = ctrl.m_high ? opb[31:16] : opb[15:0]; // RULE_03 RULE_13
  assign half_prod = half_a * half_b; // RULE_01
  assign long_prod = $signed(opa) * $signed(opb); // RULE_06
  assign word_prod = $signed(opa) * half_b; // RULE_11
  assign swap_b = ctrl.xchg ? {opb[15:0], opb[31:16]} : opb; // RULE_15
  assign dual_p1 = $signed(opa[15:0]) * $signed(swap_b[15:0]);
  assign dual_p2 = $signed(opa[31:16]) * $signed(swap_b[31:16]);
  // A 32-bit difference of two 32-bit products wraps exactly like the truncated result.
  assign dual_diff = dual_p1 - dual_p2; // RULE_14 RULE_16

  always_comb
  begin
    res.hi = long_prod[63:32];
    res.hi_wr = 1'b0;
    case (ctrl.op)
      smu_op_half: res.lo = half_prod;
      smu_op_long:
      begin
        res.lo = long_prod[31:0]; // RULE_07
        res.hi_wr = 1'b1;
      end
      smu_op_word: res.lo = word_prod[47:16]; // RULE_12
      smu_op_dual: res.lo = dual_diff;
      default: res.lo = half_prod;
    endcase
  end

endmodule

// ---- src/smu_pkg.sv ----
/*
  Shared constants and types of the signed multiply unit: register offsets, control and
  status field positions, reset values and the bundles that carry operands and control.
  Assumes a 32-bit APB master and word-aligned register addresses.
*/
package smu_pkg;

  // Data and bus widths.
  localparam int SMU_DATA_W = 32;
  localparam int SMU_HALF_W = 16;
  localparam int SMU_LANES = 4;
  localparam int SMU_FLAGS_W = 5;
  localparam int SMU_CNT_W = 8;

  // Register byte offsets.
  localparam logic [7:0] SMU_OFF_OPA = 8'h00;
  localparam logic [7:0] SMU_OFF_OPB = 8'h04;
  localparam logic [7:0] SMU_OFF_CTRL = 8'h08;
  localparam logic [7:0] SMU_OFF_RES_LO = 8'h0C;
  localparam logic [7:0] SMU_OFF_RES_HI = 8'h10;
  localparam logic [7:0] SMU_OFF_FLAGS = 8'h14;
  localparam logic [7:0] SMU_OFF_STATUS = 8'h18;

  // Control register fields.
  localparam int SMU_CTRL_OP_LSB = 0;
  localparam int SMU_CTRL_OP_MSB = 1;
  localparam int SMU_CTRL_N_HIGH = 2;
  localparam int SMU_CTRL_M_HIGH = 3;
  localparam int SMU_CTRL_XCHG = 4;
  localparam int SMU_CTRL_COND = 5;
  localparam int SMU_CTRL_GO = 8;

  // Status register fields.
  localparam int SMU_STAT_CNT_LSB = 0;
  localparam int SMU_STAT_CNT_MSB = 7;
  localparam int SMU_STAT_BUSY = 8;

  typedef enum logic [1:0] {
    smu_op_half,
    smu_op_long,
    smu_op_word,
    smu_op_dual
  } smu_op_type;

  typedef struct packed {
    logic cond_pass;
    logic xchg;
    logic m_high;
    logic n_high;
    smu_op_type op;
  } smu_ctrl_type;

  typedef struct packed {
    logic [SMU_DATA_W-1:0] lo;
    logic [SMU_DATA_W-1:0] hi;
    logic hi_wr;
  } smu_result_type;

  typedef struct packed {
    logic [SMU_DATA_W-1:0] opa;
    logic [SMU_DATA_W-1:0] opb;
    smu_ctrl_type ctrl;
    logic go;
    logic [SMU_DATA_W-1:0] res_lo;
    logic [SMU_DATA_W-1:0] res_hi;
    logic [SMU_FLAGS_W-1:0] flags;
    logic [SMU_CNT_W-1:0] done_cnt;
    logic [SMU_DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
  } smu_state_type;

  localparam smu_state_type SMU_STATE_RST = '0;

endpackage

// ---- src/smu_top.sv ----
/*
  Signed multiply unit with an APB register file: operand, control, result, flag and
  status registers around one multiply datapath.
  Assumes an APB master on the same clock; operation timing is fixed at one cycle.
*/
// Local design decisions: the APB register port and the address map.
// Function
// [RULE_01] Halfword multiply forms the full signed 32-bit product of two halfwords.
// [RULE_02] First select bit picks first operand upper half, else lower half.
// [RULE_03] Second select bit picks second operand upper half, else lower half.
// [RULE_04] Halfword and word-halfword multiplies never flag overflow nor touch flags.
// [RULE_05] Decode treats halfword multiply naming register 13 or 15 as unpredictable.
// [RULE_06] Long multiply forms the exact signed 64-bit product of two words.
// [RULE_07] Long multiply writes bits 63..32 high, bits 31..0 low.
// [RULE_08] Decode treats equal long multiply destinations as unpredictable.
// [RULE_09] Decode treats long multiply naming register 13 or 15 as unpredictable.
// [RULE_10] Long multiply updates no condition flags.
// [RULE_11] Word-halfword multiply writes bits 47..16 of the 48-bit product.
// [RULE_12] Word-halfword multiply drops the lowest 16 product bits without rounding.
// [RULE_13] Word-halfword select bit picks upper half when set, lower when clear.
// [RULE_14] Dual multiply-subtract subtracts second product from first, never flags overflow.
// [RULE_15] Exchange pairs bottom with top and top with bottom halves.
// [RULE_16] Dual result is low-halves product minus high-halves product, truncated.
// [RULE_17] A failed condition leaves all destination registers unchanged.
`timescale 1ns/1ns

module smu_top (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // APB request
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import smu_pkg::*;

  smu_state_type st_r;
  smu_state_type st_nxt;
  smu_result_type core_res;
  smu_ctrl_type ctrl_new;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] ctrl_merged;
  logic access_first;
  logic access_done;
  logic mapped;
  logic exec;

  // Byte lane mask from the write strobes.
  genvar lane;
  generate
    for (lane = 0; lane < SMU_LANES; lane++)
    begin : g_lane
      assign wmask[8*lane +: 8] = {8{pstrb[lane]}};
    end
  endgenerate

  smu_mul_core u_core (
    .opa(st_r.opa),
    .opb(st_r.opb),
    .ctrl(st_r.ctrl),
    .res(core_res)
  );

  // The answer is registered, so every access phase lasts two cycles.
  assign access_first = psel && penable && !st_r.ready;
  assign access_done = psel && penable && st_r.ready;
  assign exec = st_r.go && st_r.ctrl.cond_pass;

  always_comb
  begin
    mapped = 1'b0;
    case (paddr[7:0])
      SMU_OFF_OPA, SMU_OFF_OPB, SMU_OFF_CTRL, SMU_OFF_RES_LO,
      SMU_OFF_RES_HI, SMU_OFF_FLAGS, SMU_OFF_STATUS: mapped = (paddr[31:8] == 24'h00_0000);
      default: mapped = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[SMU_CTRL_OP_MSB:SMU_CTRL_OP_LSB] = st_r.ctrl.op;
    ctrl_word[SMU_CTRL_N_HIGH] = st_r.ctrl.n_high;
    ctrl_word[SMU_CTRL_M_HIGH] = st_r.ctrl.m_high;
    ctrl_word[SMU_CTRL_XCHG] = st_r.ctrl.xchg;
    ctrl_word[SMU_CTRL_COND] = st_r.ctrl.cond_pass;
    status_word = 32'h0000_0000;
    status_word[SMU_STAT_CNT_MSB:SMU_STAT_CNT_LSB] = st_r.done_cnt;
    status_word[SMU_STAT_BUSY] = st_r.go;
  end

  always_comb
  begin
    ctrl_merged = (ctrl_word & ~wmask) | (pwdata & wmask);
    ctrl_new.op = smu_op_type'(ctrl_merged[SMU_CTRL_OP_MSB:SMU_CTRL_OP_LSB]);
    ctrl_new.n_high = ctrl_merged[SMU_CTRL_N_HIGH];
    ctrl_new.m_high = ctrl_merged[SMU_CTRL_M_HIGH];
    ctrl_new.xchg = ctrl_merged[SMU_CTRL_XCHG];
    ctrl_new.cond_pass = ctrl_merged[SMU_CTRL_COND];
  end

  always_comb
  begin
    case (paddr[7:0])
      SMU_OFF_OPA: rd_word = st_r.opa;
      SMU_OFF_OPB: rd_word = st_r.opb;
      SMU_OFF_CTRL: rd_word = ctrl_word;
      SMU_OFF_RES_LO: rd_word = st_r.res_lo;
      SMU_OFF_RES_HI: rd_word = st_r.res_hi;
      SMU_OFF_FLAGS: rd_word = {27'h000_0000, st_r.flags};
      SMU_OFF_STATUS: rd_word = status_word;
      default: rd_word = 32'h0000_0000;
    endcase
    if (!mapped)
    begin
      rd_word = 32'h0000_0000;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ready = access_first;
    st_nxt.slverr = access_first && !mapped;
    st_nxt.go = 1'b0;
    if (access_first)
    begin
      st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_word;
    end
    // Writes land only at the edge where the master sees pready high.
    if (access_done && pwrite && mapped)
    begin
      case (paddr[7:0])
        SMU_OFF_OPA: st_nxt.opa = (st_r.opa & ~wmask) | (pwdata & wmask);
        SMU_OFF_OPB: st_nxt.opb = (st_r.opb & ~wmask) | (pwdata & wmask);
        SMU_OFF_CTRL:
        begin
          st_nxt.ctrl = ctrl_new;
          st_nxt.go = ctrl_merged[SMU_CTRL_GO];
        end
        SMU_OFF_FLAGS:
        begin
          st_nxt.flags = (st_r.flags & ~wmask[4:0]) | (pwdata[4:0] & wmask[4:0]);
        end
        default: st_nxt.flags = st_r.flags;
      endcase
    end
    // The flag register belongs to software alone; no operation writes it.
    if (exec) // RULE_17
    begin
      st_nxt.res_lo = core_res.lo; // RULE_01 RULE_11 RULE_14
      if (core_res.hi_wr)
      begin
        st_nxt.res_hi = core_res.hi; // RULE_07
      end
      st_nxt.done_cnt = st_r.done_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= SMU_STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slverr;

  // Reference values, computed apart from the datapath, for the checks below.
  logic signed [31:0] chk_bb;
  logic signed [31:0] chk_tb;
  logic signed [31:0] chk_bt;
  logic signed [31:0] chk_tt;
  logic signed [63:0] chk_long;
  logic signed [47:0] chk_wb;
  logic signed [47:0] chk_wt;
  logic signed [31:0] chk_dual;
  logic signed [31:0] chk_dualx;

  assign chk_bb = $signed(st_r.opa[15:0]) * $signed(st_r.opb[15:0]);
  assign chk_tb = $signed(st_r.opa[31:16]) * $signed(st_r.opb[15:0]);
  assign chk_bt = $signed(st_r.opa[15:0]) * $signed(st_r.opb[31:16]);
  assign chk_tt = $signed(st_r.opa[31:16]) * $signed(st_r.opb[31:16]);
  assign chk_long = $signed(st_r.opa) * $signed(st_r.opb);
  assign chk_wb = $signed(st_r.opa) * $signed(st_r.opb[15:0]);
  assign chk_wt = $signed(st_r.opa) * $signed(st_r.opb[31:16]);
  assign chk_dual = chk_bb - $signed(st_r.opa[31:16]) * $signed(st_r.opb[31:16]);
  assign chk_dualx = chk_bt - chk_tb;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_run(smu_op_type op_sel);
    exec && st_r.ctrl.op == op_sel;
  endsequence

  sequence s_settled;
    !st_r.go ##1 !st_r.go;
  endsequence

  property p_half_bb;
    s_run(smu_op_half) and (!st_r.ctrl.n_high && !st_r.ctrl.m_high)
      |=> st_r.res_lo == $past(chk_bb);
  endproperty
  a_half_bb: assert property (p_half_bb) // RULE_01
    else $error("halfword bottom by bottom product wrong");

  property p_half_first_top;
    s_run(smu_op_half) and (st_r.ctrl.n_high && !st_r.ctrl.m_high)
      |=> st_r.res_lo == $past(chk_tb);
  endproperty
  a_half_first_top: assert property (p_half_first_top) // RULE_02
    else $error("first operand top half not used");

  property p_half_second_top;
    s_run(smu_op_half) and (!st_r.ctrl.n_high && st_r.ctrl.m_high)
      |=> st_r.res_lo == $past(chk_bt);
  endproperty
  a_half_second_top: assert property (p_half_second_top) // RULE_03
    else $error("second operand top half not used");

  property p_half_both_top;
    s_run(smu_op_half) and (st_r.ctrl.n_high && st_r.ctrl.m_high)
      |=> st_r.res_lo == $past(chk_tt);
  endproperty
  a_half_both_top: assert property (p_half_both_top) // RULE_02
    else $error("top by top halfword product wrong");

  property p_flags_kept;
    exec |=> st_r.flags == $past(st_r.flags) ##1 $stable(st_r.flags);
  endproperty
  a_flags_kept: assert property (p_flags_kept) // RULE_04
    else $error("an operation changed the flag register");

  property p_long_low;
    s_run(smu_op_long) |=> st_r.res_lo == $past(chk_long[31:0]);
  endproperty
  a_long_low: assert property (p_long_low) // RULE_06
    else $error("long product low word wrong");

  property p_long_high;
    s_run(smu_op_long) |=> st_r.res_hi == $past(chk_long[63:32]) ##1 s_settled;
  endproperty
  a_long_high: assert property (p_long_high) // RULE_07
    else $error("long product high word wrong");

  property p_long_no_flags;
    s_run(smu_op_long) |=> $stable(st_r.flags) [*2];
  endproperty
  a_long_no_flags: assert property (p_long_no_flags) // RULE_10
    else $error("long multiply touched the flags");

  property p_word_top;
    s_run(smu_op_word) and st_r.ctrl.m_high |=> st_r.res_lo == $past(chk_wt[47:16]);
  endproperty
  a_word_top: assert property (p_word_top) // RULE_13
    else $error("word by top halfword result wrong");

  property p_word_truncate;
    s_run(smu_op_word) and !st_r.ctrl.m_high |=> st_r.res_lo == $past(chk_wb[47:16]);
  endproperty
  a_word_truncate: assert property (p_word_truncate) // RULE_12
    else $error("word by halfword result rounded or shifted wrong");

  property p_word_single_dest;
    s_run(smu_op_word) |=> $stable(st_r.res_hi);
  endproperty
  a_word_single_dest: assert property (p_word_single_dest) // RULE_11
    else $error("word by halfword wrote the high result");

  property p_dual_plain;
    s_run(smu_op_dual) and !st_r.ctrl.xchg |=> st_r.res_lo == $past(chk_dual);
  endproperty
  a_dual_plain: assert property (p_dual_plain) // RULE_16
    else $error("dual multiply subtract result wrong");

  property p_dual_swap;
    s_run(smu_op_dual) and st_r.ctrl.xchg |=> st_r.res_lo == $past(chk_dualx);
  endproperty
  a_dual_swap: assert property (p_dual_swap) // RULE_15
    else $error("exchanged dual multiply subtract result wrong");

  property p_dual_high_kept;
    s_run(smu_op_dual) |=> $stable(st_r.res_hi) && $stable(st_r.flags);
  endproperty
  a_dual_high_kept: assert property (p_dual_high_kept) // RULE_14
    else $error("dual multiply subtract wrote beyond one word");

  property p_cond_fail;
    st_r.go && !st_r.ctrl.cond_pass |=> $stable(st_r.res_lo) && $stable(st_r.res_hi)
      && $stable(st_r.done_cnt);
  endproperty
  a_cond_fail: assert property (p_cond_fail) // RULE_17
    else $error("failed condition changed a result register");

  property p_idle_kept;
    !exec |=> $stable(st_r.res_lo) && $stable(st_r.res_hi) && $stable(st_r.done_cnt);
  endproperty
  a_idle_kept: assert property (p_idle_kept) // RULE_17
    else $error("result registers changed without an operation");

  property p_count_step;
    exec |=> st_r.done_cnt == $past(st_r.done_cnt) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) // RULE_17
    else $error("operation count did not step by one");

  property p_go_pulse;
    st_r.go |=> !st_r.go;
  endproperty
  a_go_pulse: assert property (p_go_pulse)
    else $error("start request lasted more than one cycle");

  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error response without pready");

  property p_err_rdata_zero;
    pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_rdata_zero: assert property (p_err_rdata_zero)
    else $error("refused access returned nonzero data");

  property p_ready_pulse;
    access_first |=> pready ##1 !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready not a single cycle answer");

endmodule

// ---- tb/signed_multiply_unit_bench.sv ----
/*
  Self-checking bench of the signed multiply unit: a behavioural model predicts every
  result register. Assumes the decode model in its own file drives the APB port.
*/
`timescale 1ns/1ns

module signed_multiply_unit_bench;
  import smu_pkg::*;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, tmo, er, cond;
  logic [31:0] paddr, pwdata, prdata, rd, a, b, c, ctrl, m_lo, m_hi, m_cnt;
  logic [63:0] r;
  logic [3:0] pstrb;
  int fails, checks;

  smu_top u_smu_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  smu_decode_model u_smu_decode_model (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmo(tmo));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task summarize;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task xf(input logic w, input logic [31:0] ad, input logic [31:0] d, input logic [3:0] s);
    u_smu_decode_model.xfer(w, ad, d, s, rd, er);
    if (tmo)
    begin
      $display("[ERR] %0t no answer", $time);
      fails++;
      summarize;
    end
  endtask

  task rdc(input logic [31:0] ad, input logic [31:0] exp, input logic experr);
    xf(1'b0, ad, 32'h0000_0000, 4'h0);
    checks++;
    if (rd !== exp || er !== experr)
    begin
      $display("[ERR] %0t addr %h got %h/%b exp %h/%b", $time, ad, rd, er, exp, experr);
      fails++;
    end
  endtask

  // Result pair {high, low}; the high word only changes on the long multiply.
  function automatic logic [63:0] model(logic [1:0] op, logic [31:0] x, logic [31:0] y,
                                        logic [4:2] sel, logic [31:0] hi);
    longint p;
    logic [31:0] y2;
    logic [15:0] h1, h2;
    y2 = sel[4] ? {y[15:0], y[31:16]} : y;
    h1 = sel[2] ? x[31:16] : x[15:0];
    h2 = sel[3] ? y[31:16] : y[15:0];
    case (op)
      2'd0: p = longint'($signed(h1)) * longint'($signed(h2));
      2'd1: p = longint'($signed(x)) * longint'($signed(y));
      2'd2: p = (longint'($signed(x)) * longint'($signed(h2))) >>> 16;
      default: p = longint'($signed(x[15:0])) * longint'($signed(y2[15:0]))
                   - longint'($signed(x[31:16])) * longint'($signed(y2[31:16]));
    endcase
    return {(op == 2'd1) ? p[63:32] : hi, p[31:0]};
  endfunction

  initial
  begin
    rst_n = 1'b0;
    fails = 0;
    checks = 0;
    m_lo = 32'h0000_0000;
    m_hi = 32'h0000_0000;
    m_cnt = 32'h0000_0000;
    void'($urandom(32'h7a8f_1db6));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 7; i++)
      rdc(32'(i * 4), 32'h0000_0000, 1'b0);
    rdc(32'h0000_001c, 32'h0000_0000, 1'b1);
    rdc(32'h0000_0100, 32'h0000_0000, 1'b1);
    xf(1'b1, 32'(SMU_OFF_FLAGS), 32'h0000_0015, 4'hf);
    xf(1'b1, 32'(SMU_OFF_RES_LO), 32'hffff_ffff, 4'hf);
    rdc(32'(SMU_OFF_RES_LO), 32'h0000_0000, 1'b0);
    xf(1'b1, 32'(SMU_OFF_OPA), 32'h0000_0000, 4'hf);
    xf(1'b1, 32'(SMU_OFF_OPA), 32'haabb_ccdd, 4'h5);
    rdc(32'(SMU_OFF_OPA), 32'h00bb_00dd, 1'b0);
    for (int i = 0; i < 48; i++)
    begin
      a = $urandom;
      b = $urandom;
      c = $urandom;
      if (i % 8 < 4)
      begin
        a = 32'h8000_8000;
        b = (i % 8 < 2) ? 32'h8000_7fff : 32'h7fff_8000;
      end
      cond = (i % 5 != 4);
      ctrl = {23'h00_0000, 1'b1, 2'b00, cond, c[4:2], 2'(i)};
      xf(1'b1, 32'(SMU_OFF_OPA), a, 4'hf);
      xf(1'b1, 32'(SMU_OFF_OPB), b, 4'hf);
      xf(1'b1, 32'(SMU_OFF_CTRL), ctrl, 4'hf);
      if (cond)
      begin
        r = model(2'(i), a, b, c[4:2], m_hi);
        m_lo = r[31:0];
        m_hi = r[63:32];
        m_cnt = (m_cnt + 1) & 32'h0000_00ff;
      end
      rdc(32'(SMU_OFF_RES_LO), m_lo, 1'b0);
      rdc(32'(SMU_OFF_RES_HI), m_hi, 1'b0);
      rdc(32'(SMU_OFF_STATUS), m_cnt, 1'b0);
      rdc(32'(SMU_OFF_FLAGS), 32'h0000_0015, 1'b0);
      rdc(32'(SMU_OFF_CTRL), ctrl & 32'h0000_00ff, 1'b0);
    end
    summarize;
  end
endmodule

// ---- tb/smu_decode_model.sv ----
/*
  Decode side of the signed multiply unit: an APB master that loads operands, issues
  operations and reads results. Assumes the unit answers each access with a pready pulse.
*/
`timescale 1ns/1ns

module smu_decode_model (
  // Clock
  input logic clock,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // APB answer
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Status
  output logic tmo
);
  // Register numbers never reach the unit, so unpredictable encodings are never issued.
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    tmo = 1'b0;
  end

  // The request stands until the edge that samples pready high; the answer is taken there.
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1)
      tmo = 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
